// file: smu_pkg.sv
// Constants, types and decode helpers for the signed multiply unit
// Overview of operation
// - Halfword form takes first operand from first_src[15:0] when its select is 0, else [31:16].
// - Halfword form takes second operand from second_src[15:0] when its select is 0, else [31:16].
// - The unselected half of each source never influences the halfword result.
// - Halfword operands are sign-extended and multiplied signed; the full 32-bit product goes to dest_reg, no overflow.
// - Halfword form never changes the N, Z, C, V or Q flags.
// - Both forms run only when execute_predicate passes; always_predicate runs unconditionally.
// - Long form multiplies two signed 32-bit operands into an exact 64-bit product.
// - Long form writes product[63:32] to result_high_reg and product[31:0] to result_low_reg.
// - Bit 20 is flag_update_bit; clear leaves program_status_word untouched, set updates flags.
// - With flag_update_bit set, N takes high[31] and Z is set only when the whole 64-bit result is zero.
// - With flag_update_bit set, C and V keep their previous values.
// - Any early termination is decided from the second_src value.
package smu_pkg;

   localparam int ADDR_W = 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_INSTR  = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_FIRST  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_SECOND = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_PSW    = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_RES_HI = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_RES_LO = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_DEST   = 8'h20;

   // Flag positions in program_status_word
   localparam int PSW_N = 31;
   localparam int PSW_Z = 30;
   localparam int PSW_C = 29;
   localparam int PSW_V = 28;
   localparam int PSW_Q = 27;

   // Control and status bits
   localparam int CTRL_START  = 0;
   localparam int ST_BUSY     = 0;
   localparam int ST_DONE     = 1;
   localparam int ST_EXEC     = 2;
   localparam int ST_UNDEF    = 3;
   localparam int ST_TWO_DEST = 4;
   localparam int ST_PC_USE   = 5;

   // Instruction field positions
   localparam int F_S_BIT = 20;
   localparam int F_XSEL  = 5;
   localparam int F_YSEL  = 6;

   // Opcode patterns: bits 27..20 and 7..4
   localparam logic [7:0] HW_OP_VAL  = 8'h16;
   localparam logic [7:0] HW_OP_MSK  = 8'hFF;
   localparam logic [3:0] HW_LO_VAL  = 4'h8;
   localparam logic [3:0] HW_LO_MSK  = 4'h9;
   localparam logic [7:0] LG_OP_VAL  = 8'h0C;
   localparam logic [7:0] LG_OP_MSK  = 8'hFE;
   localparam logic [3:0] LG_LO_VAL  = 4'h9;
   localparam logic [3:0] LG_LO_MSK  = 4'hF;

   localparam logic [3:0] COND_ALWAYS = 4'hE;
   localparam logic [3:0] PC_INDEX    = 4'hF;
   localparam logic [2:0] HSIZE_WORD  = 3'h2;

   // Cycle counts after early termination on second_src
   localparam logic [2:0] LAT_SHORT = 3'h1;
   localparam logic [2:0] LAT_MID   = 3'h2;
   localparam logic [2:0] LAT_FULL  = 3'h4;

   typedef enum logic {SMU_IDLE, SMU_CALC} smu_state_t;

   typedef struct packed {
      logic       hw;
      logic       lng;
      logic       s_bit;
      logic       xsel;
      logic       ysel;
      logic [3:0] cond;
      logic [3:0] rd_a;
      logic [3:0] rd_b;
      logic [3:0] rs;
      logic [3:0] rm;
   } smu_dec_t;

   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } smu_flags_t;

   function automatic logic smu_cond_pass(input logic [3:0] cond,
                                          input smu_flags_t f);
      logic base;
      base = 1'b0;
      case (cond[3:1])
         3'h0: base = f.z;
         3'h1: base = f.c;
         3'h2: base = f.n;
         3'h3: base = f.v;
         3'h4: base = f.c & ~f.z;
         3'h5: base = (f.n == f.v);
         3'h6: base = ~f.z & (f.n == f.v);
         default: base = 1'b1;
      endcase
      if (cond == COND_ALWAYS) begin
         smu_cond_pass = 1'b1;
      end else if (cond[3:1] == COND_ALWAYS[3:1]) begin
         smu_cond_pass = 1'b0;
      end else begin
         smu_cond_pass = base ^ cond[0];
      end
   endfunction

endpackage

// file: smu_top.sv
// Signed multiply unit with an AHB-Lite register slave
`timescale 1ns/1ns
module smu_top
   import smu_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata
);

   // Reset release through two flops
   logic rst_meta_r;
   logic rst_sync_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   logic [31:0]       instr_r,    instr_nxt;
   logic [31:0]       first_r,    first_nxt;
   logic [31:0]       second_r,   second_nxt;
   logic [31:0]       psw_r,      psw_nxt;
   logic [31:0]       res_hi_r,   res_hi_nxt;
   logic [31:0]       res_lo_r,   res_lo_nxt;
   logic [3:0]        dest_a_r,   dest_a_nxt;
   logic [3:0]        dest_b_r,   dest_b_nxt;
   logic [5:0]        status_r,   status_nxt;
   smu_state_t        state_r,    state_nxt;
   logic [2:0]        cnt_r,      cnt_nxt;
   logic              wr_pend_r,  wr_pend_nxt;
   logic              rd_pend_r,  rd_pend_nxt;
   logic [ADDR_W-1:0] addr_r,     addr_nxt;
   logic              hready_r,   hready_nxt;
   logic [31:0]       hrdata_r,   hrdata_nxt;

   smu_dec_t          dec;
   smu_flags_t        flg;
   logic              pass;
   logic [15:0]       op1_half;
   logic [15:0]       op2_half;
   logic [31:0]       hw_prod;
   logic [63:0]       lg_prod;
   logic [2:0]        lat;
   logic [31:0]       rd_mux;
   logic              acc;

   // Decode of the held instruction word
   always_comb begin
      dec.hw    = ((instr_r[27:20] & HW_OP_MSK) == HW_OP_VAL) &&
                  ((instr_r[7:4] & HW_LO_MSK) == HW_LO_VAL);
      dec.lng   = ((instr_r[27:20] & LG_OP_MSK) == LG_OP_VAL) &&
                  ((instr_r[7:4] & LG_LO_MSK) == LG_LO_VAL);
      dec.s_bit = instr_r[F_S_BIT];
      dec.xsel  = instr_r[F_XSEL];
      dec.ysel  = instr_r[F_YSEL];
      dec.cond  = instr_r[31:28];
      dec.rd_a  = instr_r[19:16];
      dec.rd_b  = instr_r[15:12];
      dec.rs    = instr_r[11:8];
      dec.rm    = instr_r[3:0];
   end

   assign flg.n = psw_r[PSW_N];
   assign flg.z = psw_r[PSW_Z];
   assign flg.c = psw_r[PSW_C];
   assign flg.v = psw_r[PSW_V];
   assign pass  = smu_cond_pass(dec.cond, flg);

   // Operand halves; the other half never reaches the multiplier
   assign op1_half = dec.xsel ? first_r[31:16] : first_r[15:0];
   assign op2_half = dec.ysel ? second_r[31:16] : second_r[15:0];
   assign hw_prod  = $signed(op1_half) * $signed(op2_half);
   assign lg_prod  = $signed(first_r) * $signed(second_r);

   // Signed early termination on second_src magnitude
   always_comb begin
      if (dec.hw) begin
         lat = LAT_SHORT;
      end else if (second_r[31:7] == {25{second_r[7]}}) begin
         lat = LAT_SHORT;
      end else if (second_r[31:15] == {17{second_r[15]}}) begin
         lat = LAT_MID;
      end else begin
         lat = LAT_FULL;
      end
   end

   // Read data mux
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (addr_r == OFS_INSTR) begin
         rd_mux = instr_r;
      end else if (addr_r == OFS_FIRST) begin
         rd_mux = first_r;
      end else if (addr_r == OFS_SECOND) begin
         rd_mux = second_r;
      end else if (addr_r == OFS_PSW) begin
         rd_mux = psw_r;
      end else if (addr_r == OFS_STATUS) begin
         rd_mux = {26'h000_0000, status_r};
      end else if (addr_r == OFS_RES_HI) begin
         rd_mux = res_hi_r;
      end else if (addr_r == OFS_RES_LO) begin
         rd_mux = res_lo_r;
      end else if (addr_r == OFS_DEST) begin
         rd_mux = {24'h00_0000, dest_b_r, dest_a_r};
      end
   end

   assign acc = hsel & htrans[1] & hready;

   always_comb begin
      instr_nxt   = instr_r;
      first_nxt   = first_r;
      second_nxt  = second_r;
      psw_nxt     = psw_r;
      res_hi_nxt  = res_hi_r;
      res_lo_nxt  = res_lo_r;
      dest_a_nxt  = dest_a_r;
      dest_b_nxt  = dest_b_r;
      status_nxt  = status_r;
      state_nxt   = state_r;
      cnt_nxt     = cnt_r;
      wr_pend_nxt = 1'b0;
      rd_pend_nxt = 1'b0;
      addr_nxt    = addr_r;
      hready_nxt  = hready_r;
      hrdata_nxt  = hrdata_r;

      // Address phase; reads take one wait state so hrdata is a flop
      if (acc) begin
         addr_nxt = haddr[ADDR_W-1:0];
         if (hwrite) begin
            wr_pend_nxt = (hsize == HSIZE_WORD);
         end else begin
            rd_pend_nxt = 1'b1;
            hready_nxt  = 1'b0;
         end
      end
      if (rd_pend_r) begin
         hrdata_nxt = rd_mux;
         hready_nxt = 1'b1;
      end

      // Operand writes are dropped while a multiply runs
      if (wr_pend_r && state_r == SMU_IDLE) begin
         if (addr_r == OFS_INSTR) begin
            instr_nxt = hwdata;
         end else if (addr_r == OFS_FIRST) begin
            first_nxt = hwdata;
         end else if (addr_r == OFS_SECOND) begin
            second_nxt = hwdata;
         end else if (addr_r == OFS_PSW) begin
            psw_nxt = hwdata;
         end else if (addr_r == OFS_CTRL && hwdata[CTRL_START]) begin
            status_nxt[ST_DONE]     = 1'b0;
            status_nxt[ST_EXEC]     = 1'b0;
            status_nxt[ST_TWO_DEST] = dec.lng;
            status_nxt[ST_UNDEF]    = ~(dec.hw | dec.lng);
            status_nxt[ST_PC_USE]   = dec.hw &&
               (dec.rd_a == PC_INDEX || dec.rs == PC_INDEX ||
                dec.rm == PC_INDEX);
            if ((dec.hw || dec.lng) && pass) begin
               state_nxt           = SMU_CALC;
               cnt_nxt             = lat;
               status_nxt[ST_BUSY] = 1'b1;
            end else begin
               // Failed predicate or unknown pattern: nothing written
               status_nxt[ST_DONE] = 1'b1;
            end
         end
      end

      case (state_r)
         SMU_IDLE: begin
         end
         SMU_CALC: begin
            cnt_nxt = cnt_r - LAT_SHORT;
            if (cnt_r == LAT_SHORT) begin
               state_nxt           = SMU_IDLE;
               status_nxt[ST_BUSY] = 1'b0;
               status_nxt[ST_DONE] = 1'b1;
               status_nxt[ST_EXEC] = 1'b1;
               dest_a_nxt          = dec.rd_a;
               if (dec.hw) begin
                  // Flags left alone for the halfword form
                  res_lo_nxt = hw_prod;
                  dest_b_nxt = dec.rd_a;
               end else begin
                  res_hi_nxt = lg_prod[63:32];
                  res_lo_nxt = lg_prod[31:0];
                  dest_b_nxt = dec.rd_b;
                  if (dec.s_bit) begin
                     psw_nxt[PSW_N] = lg_prod[63];
                     psw_nxt[PSW_Z] = (lg_prod == 64'h0);
                  end
               end
            end
         end
         default: begin
            state_nxt = SMU_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         instr_r   <= 32'h0000_0000;
         first_r   <= 32'h0000_0000;
         second_r  <= 32'h0000_0000;
         psw_r     <= 32'h0000_0000;
         res_hi_r  <= 32'h0000_0000;
         res_lo_r  <= 32'h0000_0000;
         dest_a_r  <= 4'h0;
         dest_b_r  <= 4'h0;
         status_r  <= 6'h00;
         state_r   <= SMU_IDLE;
         cnt_r     <= 3'h0;
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r    <= '0;
         hready_r  <= 1'b1;
         hrdata_r  <= 32'h0000_0000;
      end else begin
         instr_r   <= instr_nxt;
         first_r   <= first_nxt;
         second_r  <= second_nxt;
         psw_r     <= psw_nxt;
         res_hi_r  <= res_hi_nxt;
         res_lo_r  <= res_lo_nxt;
         dest_a_r  <= dest_a_nxt;
         dest_b_r  <= dest_b_nxt;
         status_r  <= status_nxt;
         state_r   <= state_nxt;
         cnt_r     <= cnt_nxt;
         wr_pend_r <= wr_pend_nxt;
         rd_pend_r <= rd_pend_nxt;
         addr_r    <= addr_nxt;
         hready_r  <= hready_nxt;
         hrdata_r  <= hrdata_nxt;
      end
   end

   assign hreadyout = hready_r;
   assign hrdata    = hrdata_r;

   // Response is always OKAY
   logic hresp_r;
   always_ff @(posedge mclk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         hresp_r <= 1'b0;
      end else begin
         hresp_r <= 1'b0;
      end
   end
   assign hresp = hresp_r;

endmodule

// file: smu_top_properties.sv
// Bus protocol checker bound to the signed multiply unit
`timescale 1ns/1ns
module smu_top_properties
   import smu_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence take_s;
      hsel && htrans[1] && hready;
   endsequence
   sequence rd_s;
      take_s ##0 !hwrite;
   endsequence
   sequence wr_s;
      take_s ##0 hwrite;
   endsequence

   hresp_okay_a: assert property (hresp == 1'b0)
      else $error("hresp not OKAY");
   read_wait_a: assert property (rd_s |=> !hreadyout ##1 hreadyout)
      else $error("read did not take exactly one wait");
   write_nowait_a: assert property (wr_s |=> hreadyout)
      else $error("write was stalled");
   wait_single_a: assert property (!hreadyout |=> hreadyout)
      else $error("wait state longer than one cycle");
   wait_cause_a: assert property
      ($fell(hreadyout) |-> $past(hsel && htrans[1] && !hwrite))
      else $error("wait state without a read");
   rdata_hold_a: assert property
      (hreadyout && $past(hreadyout) |-> $stable(hrdata))
      else $error("hrdata moved outside a read");
   ctrl_zero_a: assert property
      (rd_s ##0 (haddr[7:0] == OFS_CTRL) |=> ##1 hrdata == 32'h0)
      else $error("control word read not zero");
   unmapped_zero_a: assert property
      (rd_s ##0 (haddr[7:0] >= 8'h24) |=> ##1 hrdata == 32'h0)
      else $error("unmapped read not zero");
endmodule

bind smu_top smu_top_properties i_smu_top_properties (
   .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata));

// file: smu_bus_master.sv
// Bus master model standing in for the processor side
`timescale 1ns/1ns
module smu_bus_master
   import smu_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = HSIZE_WORD;
      hwdata = 32'h0;
   end

   // Released haddr and hwdata show the inverse, so stale values never look valid
   task automatic xfer(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hsize <= HSIZE_WORD;
      do @(posedge mclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= ~a;
      hwdata <= d;
      do @(posedge mclk); while (hready !== 1'b1);
      q = hrdata;
      hwdata <= ~d;
   endtask
endmodule

// file: signed_multiply_unit_tb_top.sv
// Self-checking testbench for the signed multiply unit
`timescale 1ns/1ns
module signed_multiply_unit_tb_top
   import smu_pkg::*;
;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hi_prev, lo_prev;
   int          mismatches = 0;
   int          checks = 0;

   always #4 mclk = ~mclk;

   smu_top i_smu_top (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata));
   smu_bus_master i_smu_bus_master (.mclk(mclk), .hready(hreadyout),
      .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   task automatic end_sim;
      $display("TB: mismatches=%0d checks=%0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] o, input logic [31:0] d);
      logic [31:0] q;
      i_smu_bus_master.xfer(1'b1, {24'h0, o}, d, q);
   endtask

   task automatic rd(input logic [7:0] o, output logic [31:0] q);
      i_smu_bus_master.xfer(1'b0, {24'h0, o}, 32'h0, q);
   endtask

   // Register fields stay clear of program_counter_reg
   function automatic logic [31:0] hw_ins(logic x, logic y);
      return {COND_ALWAYS, HW_OP_VAL, 4'h1, 4'h0, 4'h2, 1'b1, y, x,
              1'b0, 4'h3};
   endfunction

   task automatic op(input logic [31:0] ins, a, b, psw,
                     output logic [31:0] st);
      wr(OFS_INSTR, ins);
      wr(OFS_FIRST, a);
      wr(OFS_SECOND, b);
      wr(OFS_PSW, psw);
      wr(OFS_CTRL, 32'h1);
      for (int n = 0; n < 30; n++) begin
         rd(OFS_STATUS, st);
         if (st[ST_DONE] === 1'b1 && st[ST_BUSY] === 1'b0) break;
      end
   endtask

   task automatic one_long(input logic [3:0] c, input logic s,
                           input logic [31:0] a, b, psw, input logic ok);
      logic [31:0] st, q, ep;
      logic [63:0] p;
      p = $signed(a) * $signed(b);
      op({c, LG_OP_VAL[7:1], s, 4'h4, 4'h5, 4'h2, 4'h9, 4'h3}, a, b, psw, st);
      chk(st & 32'h3F, ok ? 32'h16 : 32'h12);
      if (ok) begin
         {hi_prev, lo_prev} = p;
         rd(OFS_DEST, q);
         chk(q, 32'h0000_0054);
      end
      rd(OFS_RES_HI, q);
      chk(q, hi_prev);
      rd(OFS_RES_LO, q);
      chk(q, lo_prev);
      ep = (ok && s) ? {hi_prev[31], {hi_prev, lo_prev} == 64'h0,
                        psw[29:0]} : psw;
      rd(OFS_PSW, q);
      chk(q, ep);
   endtask

   // Second operand widths walk every early-termination length
   task automatic sc_long;
      one_long(COND_ALWAYS, 1'b1, 32'h7FFFFFFF, 32'h5, 32'h30000000, 1'b1);
      one_long(COND_ALWAYS, 1'b1, 32'h12345678, 32'hFFFF8000, 32'h0, 1'b1);
      one_long(COND_ALWAYS, 1'b1, 32'h80000000, 32'h80000000, 32'hF0000000,
               1'b1);
      one_long(COND_ALWAYS, 1'b1, 32'h0, 32'h87654321, 32'h80000000, 1'b1);
      one_long(COND_ALWAYS, 1'b0, 32'hFFFFFFFF, 32'h7FFFFFFF, 32'h58000000,
               1'b1);
      one_long(4'h0, 1'b1, 32'h3, 32'h3, 32'h0, 1'b0);
      one_long(4'h0, 1'b1, 32'h3, 32'h3, 32'h40000000, 1'b1);
   endtask

   task automatic sc_halfword;
      logic [31:0] a, b, st, q;
      logic [15:0] ha, hb;
      logic signed [31:0] p;
      for (int k = 0; k < 8; k++) begin
         ha = k[0] ? 16'h8003 : 16'h7FFD;
         hb = k[1] ? 16'hFFFE : 16'h8000;
         a = k[0] ? {ha, 16'h7FFD} : {16'h8003, ha};
         b = k[1] ? {hb, 16'h8000} : {16'hFFFE, hb};
         a = k[2] ? a ^ (k[0] ? 32'h0000FFFF : 32'hFFFF0000) : a;
         p = $signed(ha) * $signed(hb);
         op(hw_ins(k[0], k[1]), a, b, 32'hF8000000, st);
         chk(st & 32'h3F, 32'h6);
         rd(OFS_DEST, q);
         chk(q, 32'h0000_0011);
         rd(OFS_RES_LO, q);
         chk(q, p);
         rd(OFS_RES_HI, q);
         chk(q, hi_prev);
         rd(OFS_PSW, q);
         chk(q, 32'hF8000000);
      end
      lo_prev = p;
   endtask

   task automatic sc_bus;
      logic [31:0] st, q;
      rd(OFS_CTRL, q);
      chk(q, 32'h0);
      rd(8'h40, q);
      chk(q, 32'h0);
      op(32'hE0000000, 32'h5, 32'h7, 32'h0, st);
      chk(st & 32'h3F, 32'hA);
      rd(OFS_RES_LO, q);
      chk(q, lo_prev);
      rd(OFS_FIRST, q);
      chk(q, 32'h5);
   endtask

   initial begin
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      sc_long();
      sc_halfword();
      sc_bus();
      end_sim();
   end

   // Whole run needs under a thousand cycles, far below the 25000-cycle limit
   initial begin
      #200000;
      mismatches++;
      end_sim();
   end
endmodule
